/* include/cbr_pkg.sv */
// constants and types for the clock buffer configuration register bank
package cbr_pkg;
	// bus address: upper four bits fixed, lower three from the strap pins
	localparam logic [3:0] ADDR_HI = 4'hd;
	// register locations
	localparam logic [7:0] REG_OE = 8'h00;
	localparam logic [7:0] REG_PLL = 8'h01;
	localparam logic [7:0] REG_SLEW = 8'h02;
	localparam logic [7:0] REG_FREQ = 8'h03;
	localparam logic [7:0] REG_RSVD4 = 8'h04;
	localparam logic [7:0] REG_REVV = 8'h05;
	localparam logic [7:0] REG_TYPE = 8'h06;
	localparam logic [7:0] REG_CNT = 8'h07;
	// writable bit masks; every other bit keeps its power-up value
	localparam logic [7:0] OE_WMASK = 8'h6a;
	localparam logic [7:0] PLL_WMASK = 8'h3b;
	localparam logic [7:0] SLEW_WMASK = 8'h6a;
	localparam logic [7:0] FREQ_WMASK = 8'h39;
	localparam logic [7:0] CNT_WMASK = 8'h1f;
	// power-up values (pll byte bits 7:6 come from the strap latch)
	localparam logic [7:0] OE_RST = 8'hff;
	localparam logic [5:0] PLL_RST_LO = 6'h06;
	localparam logic [7:0] SLEW_RST = 8'hff;
	localparam logic [7:0] FREQ_RST = 8'hc7;
	localparam logic [7:0] RSVD4_VAL = 8'hff;
	localparam logic [7:0] CNT_RST = 8'h08;
	localparam logic [7:0] UNMAPPED_VAL = 8'h00;
	// field positions
	localparam int PLL_SW_BIT = 5;
	localparam int FREQ_EN_BIT = 5;
	localparam int FB_RATE_BIT = 0;
	// part type codes
	localparam logic [1:0] TYPE_CLOCK_GENERATOR = 2'h0;
	localparam logic [1:0] TYPE_ZERO_DELAY_BUFFER = 2'h1;
	// identity values: arbitrary neutral values
	localparam logic [3:0] REVISION_ID = 4'h1;
	localparam logic [3:0] VENDOR_ID = 4'ha;
	localparam logic [5:0] PART_IDENT = 6'h2a;
	// frequency choice applied while software selection is off
	localparam logic [1:0] FREQ_DEFAULT = 2'h0;
	// bit count of one byte on the wire
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	// byte-level controller states
	typedef enum logic [5:0]
	{
		ST_IDLE = 6'h01,
		ST_RX = 6'h02,
		ST_ACK = 6'h04,
		ST_TX = 6'h08,
		ST_HACK = 6'h10,
		ST_HWAIT = 6'h20
	} cbr_state_t;
	// which byte of a transfer is being received
	typedef enum logic [1:0]
	{
		STG_ADDR = 2'h0,
		STG_CMD = 2'h1,
		STG_COUNT = 2'h2,
		STG_DATA = 2'h3
	} cbr_stage_t;
endpackage

/* rtl/cbr_regs.sv */
// two-wire slave and configuration register bank of the clock buffer
// Notes on behaviour
// R1: the slew byte holds one edge bit per output at bits 6, 5, 3 and 1.
// R2: a slew bit at 0 picks the slow edge, at 1 the fast, all bits start 1.
// R3: bit 5 of the frequency byte enables software frequency choice, start 0.
// R4: frequency bits 4:3 start 0 and act only with pll byte bit 5 set.
// R5: the pll mode control bits act only while pll byte bit 5 is set.
// R6: bit 0 of the frequency byte picks a 2.0 or 3.0 V/ns feedback edge.
// R7: byte 5 is read-only, revision in bits 7:4 and vendor in bits 3:0.
// R8: byte 6 is read-only, part type in bits 7:6 and part id in bits 5:0.
// R9: the byte count register sets the read length, writable, starts at 8.
// R10: count bits 7:5 are reserved zero, the count sits in bits 4:0.
// R11: the part is a slave on one 7-bit address doing block reads and writes.
// R12: the host may stop after any whole byte and the transfer just ends.
// R13: pll byte bit 5 picks the software mode bits, else the latched bits.
// R14: writes to read-only or reserved bits change nothing.
`timescale 1ns/1ps
module cbr_regs
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// straps sampled after reset
	input wire logic [2:0] addr_strap,
	input wire logic [1:0] pll_mode_strap,
	// configuration outputs
	output logic [3:0] out_enable,
	output logic [1:0] amplitude,
	output logic edge_rate_out_a,
	output logic edge_rate_out_b,
	output logic edge_rate_out_c,
	output logic edge_rate_out_d,
	output logic feedback_edge_rate,
	output logic freq_sw_enable,
	output logic freq_choice_hi,
	output logic freq_choice_lo,
	output logic pll_mode_sw_source,
	output logic [1:0] pll_mode,
	output logic [4:0] readback_count_field
);
	import cbr_pkg::*;

	typedef struct packed
	{
		cbr_state_t st;
		cbr_stage_t stage;
		logic rd;
		logic [3:0] bitcnt;
		logic [7:0] sh, ptr, rem;
		logic sda_drv;
		logic [2:0] scl_s, sda_s;
		logic scl_f, sda_f;
		logic strap_done;
		logic [2:0] addr_lo;
		logic [7:0] b0, b1, b2, b3, b7;
		logic [1:0] pll_eff, freq_eff;
	} cbr_st_t;
	cbr_st_t s, n;
	logic scl_rise, scl_fall, start_seen, stop_seen, ack;

	// keep only writable bits of a host byte, the rest holds
	function automatic logic [7:0] merge(input logic [7:0] d,
		input logic [7:0] m, input logic [7:0] keep);
		return (d & m) | (keep & ~m);
	endfunction
	// byte returned for a register location
	function automatic logic [7:0] reg_read(input cbr_st_t v);
		logic [7:0] r;
		r = UNMAPPED_VAL;
		if (v.ptr == REG_OE)
			r = v.b0;
		else if (v.ptr == REG_PLL)
			r = v.b1;
		else if (v.ptr == REG_SLEW)
			r = v.b2;
		else if (v.ptr == REG_FREQ)
			r = v.b3;
		else if (v.ptr == REG_RSVD4)
			r = RSVD4_VAL;
		else if (v.ptr == REG_REVV)
			r = {REVISION_ID, VENDOR_ID}; // [R7]
		else if (v.ptr == REG_TYPE)
			r = {TYPE_ZERO_DELAY_BUFFER, PART_IDENT}; // [R8]
		else if (v.ptr == REG_CNT)
			r = v.b7;
		return r;
	endfunction
	// next state: pin filtering, byte controller, register writes
	always_comb
	begin
		n = s;
		ack = 1'b0;
		// three-stage sync; the level changes once stages two and three agree
		n.scl_s = {s.scl_s[1:0], scl_in};
		n.sda_s = {s.sda_s[1:0], sda_in};
		if (s.scl_s[1] == s.scl_s[2])
			n.scl_f = s.scl_s[2];
		if (s.sda_s[1] == s.sda_s[2])
			n.sda_f = s.sda_s[2];
		scl_rise = n.scl_f & ~s.scl_f;
		scl_fall = s.scl_f & ~n.scl_f;
		start_seen = s.scl_f & n.scl_f & s.sda_f & ~n.sda_f;
		stop_seen = s.scl_f & n.scl_f & ~s.sda_f & n.sda_f;
		// straps caught once, on the first edge after reset release
		if (!s.strap_done)
		begin
			n.strap_done = 1'b1;
			n.addr_lo = addr_strap;
			n.b1[7:6] = pll_mode_strap; // [R13]
		end
		// a stop ends any transfer cleanly, whatever byte it follows
		if (stop_seen)
		begin
			n.st = ST_IDLE; // [R12]
			n.sda_drv = 1'b0;
		end
		else if (start_seen)
		begin
			n.st = ST_RX; // [R11]
			n.stage = STG_ADDR;
			n.bitcnt = 4'h0;
			n.sda_drv = 1'b0;
		end
		else
		begin
			case (s.st)
				ST_RX:
				begin
					if (scl_rise)
					begin
						n.sh = {s.sh[6:0], n.sda_f};
						n.bitcnt = s.bitcnt + 4'h1;
					end
					else if (scl_fall && s.bitcnt == BYTE_BITS)
					begin
						n.bitcnt = 4'h0;
						n.st = ST_ACK;
						ack = 1'b1;
						case (s.stage)
							STG_ADDR:
							begin
								// only our one address is answered
								if (s.sh[7:1] != {ADDR_HI, s.addr_lo})
								begin
									ack = 1'b0; // [R11]
									n.st = ST_IDLE;
								end
								n.rd = s.sh[0];
							end
							STG_CMD:
								n.ptr = s.sh;
							STG_COUNT:
								n.rem = s.sh;
							default:
							begin
								// bytes past the announced count are refused
								if (s.rem == 8'h00)
								begin
									ack = 1'b0;
									n.st = ST_IDLE;
								end
								else
								begin
									n.ptr = s.ptr + 8'h01;
									n.rem = s.rem - 8'h01;
									if (s.ptr == REG_OE)
										n.b0 = merge(s.sh, OE_WMASK, s.b0);
									else if (s.ptr == REG_PLL)
										n.b1 = merge(s.sh, PLL_WMASK, s.b1);
									else if (s.ptr == REG_SLEW)
										n.b2 = merge(s.sh, SLEW_WMASK, s.b2); // [R1]
									else if (s.ptr == REG_FREQ)
										n.b3 = merge(s.sh, FREQ_WMASK, s.b3); // [R3]
									else if (s.ptr == REG_CNT)
										n.b7 = merge(s.sh, CNT_WMASK, s.b7); // [R10]
									// read-only and reserved locations ignore data [R14]
								end
							end
						endcase
						n.sda_drv = ack;
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						n.sda_drv = 1'b0;
						if (s.stage == STG_ADDR && s.rd)
						begin
							// a block read opens with the byte count
							n.sh = {3'h0, s.b7[4:0]}; // [R9]
							n.rem = {3'h0, s.b7[4:0]};
							n.st = ST_TX;
							n.bitcnt = 4'h0;
							n.sda_drv = ~n.sh[7];
						end
						else
						begin
							n.st = ST_RX;
							if (s.stage != STG_DATA)
								n.stage = cbr_stage_t'(s.stage + 2'h1);
						end
					end
				end
				ST_TX:
				begin
					// bits change only while the clock is low
					if (scl_fall)
					begin
						if (s.bitcnt == LAST_BIT)
						begin
							n.sda_drv = 1'b0;
							n.st = ST_HACK;
						end
						else
						begin
							n.sh = {s.sh[6:0], 1'b0};
							n.bitcnt = s.bitcnt + 4'h1;
							n.sda_drv = ~s.sh[6];
						end
					end
				end
				ST_HACK:
				begin
					// a host nack ends the read without error
					if (scl_rise)
						n.st = n.sda_f ? ST_IDLE : ST_HWAIT; // [R12]
				end
				ST_HWAIT:
				begin
					if (scl_fall)
					begin
						if (s.rem == 8'h00)
							n.st = ST_IDLE; // [R9]
						else
						begin
							n.sh = reg_read(s);
							n.ptr = s.ptr + 8'h01;
							n.rem = s.rem - 8'h01;
							n.bitcnt = 4'h0;
							n.sda_drv = ~n.sh[7];
							n.st = ST_TX;
						end
					end
				end
				default:
					n.st = ST_IDLE;
			endcase
		end
		// effective modes: software bits only count with the pll byte bit 5
		n.pll_eff = n.b1[PLL_SW_BIT] ? n.b1[4:3] : n.b1[7:6]; // [R5] [R13]
		n.freq_eff = (n.b3[FREQ_EN_BIT] && n.b1[PLL_SW_BIT]) ?
			n.b3[4:3] : FREQ_DEFAULT; // [R4]
		// synchronous reset to power-up values; bus lines idle high
		if (rst)
		begin
			n = '0;
			n.st = ST_IDLE;
			n.stage = STG_ADDR;
			n.scl_s = 3'h7;
			n.sda_s = 3'h7;
			n.scl_f = 1'b1;
			n.sda_f = 1'b1;
			n.b0 = OE_RST;
			n.b1 = {2'h0, PLL_RST_LO};
			n.b2 = SLEW_RST; // [R2]
			n.b3 = FREQ_RST; // [R3] [R6]
			n.b7 = CNT_RST; // [R9]
			n.freq_eff = FREQ_DEFAULT;
		end
	end
	// the one state register
	always_ff @(posedge core_clk)
	begin
		s <= n;
	end
	// outputs straight from state flops; the pin is only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = s.sda_drv;
	assign out_enable = {s.b0[6], s.b0[5], s.b0[3], s.b0[1]};
	assign amplitude = s.b1[1:0];
	assign edge_rate_out_a = s.b2[1]; // [R1] [R2]
	assign edge_rate_out_b = s.b2[3];
	assign edge_rate_out_c = s.b2[5];
	assign edge_rate_out_d = s.b2[6];
	assign feedback_edge_rate = s.b3[FB_RATE_BIT]; // [R6]
	assign freq_sw_enable = s.b3[FREQ_EN_BIT]; // [R3]
	assign freq_choice_hi = s.freq_eff[1];
	assign freq_choice_lo = s.freq_eff[0];
	assign pll_mode_sw_source = s.b1[PLL_SW_BIT];
	assign pll_mode = s.pll_eff;
	assign readback_count_field = s.b7[4:0];
	default clocking cbr_cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence data_byte_done;
		s.st == ST_RX && s.stage == STG_DATA && scl_fall &&
			s.bitcnt == BYTE_BITS && s.rem != 8'h00;
	endsequence
	sequence addr_miss;
		s.st == ST_RX && s.stage == STG_ADDR && scl_fall &&
			s.bitcnt == BYTE_BITS && s.sh[7:1] != {ADDR_HI, s.addr_lo};
	endsequence
	sequence read_open;
		s.st == ST_ACK && s.stage == STG_ADDR && s.rd && scl_fall;
	endsequence
	slew_reserved_a: assert property ((s.b2 & ~SLEW_WMASK) == ~SLEW_WMASK) // [R1]
		else $error("slew reserved bits changed");
	slew_write_a: assert property (data_byte_done ##0 (s.ptr == REG_SLEW) |=> // [R2]
		s.b2 == (($past(s.sh) & SLEW_WMASK) | ~SLEW_WMASK))
		else $error("slew write not applied");
	freq_gate_a: assert property (!(s.b3[FREQ_EN_BIT] && s.b1[PLL_SW_BIT]) |-> // [R4]
		{freq_choice_hi, freq_choice_lo} == FREQ_DEFAULT)
		else $error("frequency choice applied while disabled");
	pll_source_a: assert property (pll_mode == // [R13]
		(s.b1[PLL_SW_BIT] ? s.b1[4:3] : s.b1[7:6]))
		else $error("pll mode source wrong");
	feedback_reset_a: assert property ($fell(rst) |-> feedback_edge_rate && // [R6]
		!freq_sw_enable)
		else $error("frequency byte power-up wrong");
	count_reserved_a: assert property (s.b7[7:5] == 3'h0) // [R10]
		else $error("count reserved bits set");
	latch_stable_a: assert property (s.strap_done |=> $stable(s.b1[7:6])) // [R14]
		else $error("latched mode bits changed");
	count_first_a: assert property (read_open |=> // [R9]
		s.st == ST_TX && s.sh == {3'h0, s.b7[4:0]})
		else $error("read did not open with byte count");
	read_limit_a: assert property (s.st == ST_HWAIT && scl_fall && // [R9]
		s.rem == 8'h00 |=> s.st == ST_IDLE && !sda_oe)
		else $error("read ran past byte count");
	addr_nack_a: assert property (addr_miss |=> !sda_oe [*2]) // [R11]
		else $error("foreign address answered");
	stop_ends_a: assert property (stop_seen |=> s.st == ST_IDLE && !sda_oe) // [R12]
		else $error("stop did not end transfer");
endmodule

/* tb/cbr_host.sv */
// two-wire bus host model that drives the configuration bank
`timescale 1ns/1ps
module cbr_host
(
	// clock
	input wire logic core_clk,
	// bus wires
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic drv = 1'b1;
	// open drain with pull-up: a released line reads high
	assign sda = drv & ~sda_oe;
	// bus clock idles high between transfers
	initial scl = 1'b1;
	// eight core cycles per level keeps each level past the sync filter
	task hp;
		repeat (8) @(negedge core_clk);
	endtask
	// start, or repeated start when entered with the clock low
	task start;
		drv = 1'b1;
		hp;
		scl = 1'b1;
		hp;
		drv = 1'b0;
		hp;
		scl = 1'b0;
		hp;
	endtask
	// stop may follow any whole byte
	task stop;
		drv = 1'b0;
		hp;
		scl = 1'b1;
		hp;
		drv = 1'b1;
		hp;
	endtask
	// data only moves while the clock is low; sampled at the end of high
	task bit1(input logic b, output logic r);
		drv = b;
		hp;
		scl = 1'b1;
		hp;
		r = sda;
		scl = 1'b0;
		hp;
	endtask
	// one byte msb first, then the ninth clock carries the ack
	task xfer(input logic [7:0] d, input logic h, output logic [7:0] q,
		output logic a);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit1(d[i], r);
			q[i] = r;
		end
		bit1(h, a);
	endtask
endmodule

/* tb/cbr_regs_bench.sv */
// self-checking bench for the clock buffer configuration bank
`timescale 1ns/1ps
module cbr_regs_bench;
	import cbr_pkg::*;
	// bus address with strap 5: write and read forms
	localparam logic [7:0] WA = 8'hda;
	localparam logic [7:0] RA = 8'hdb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic scl, sda, sda_oe, sdo;
	logic [3:0] oen;
	logic [1:0] amp;
	logic ea, eb, ec, ed, fb, fen, fhi, flo, psrc;
	logic [1:0] pmode;
	logic [4:0] cnt;
	int n_fail = 0;
	int total_checks = 0;
	// straps are fixed: the address and pll readback only latch once
	cbr_regs dut (.core_clk(core_clk), .rst(rst), .scl_in(scl),
		.sda_in(sda), .sda_out(sdo), .sda_oe(sda_oe), .addr_strap(3'h5),
		.pll_mode_strap(2'h1), .out_enable(oen), .amplitude(amp),
		.edge_rate_out_a(ea), .edge_rate_out_b(eb), .edge_rate_out_c(ec),
		.edge_rate_out_d(ed), .feedback_edge_rate(fb),
		.freq_sw_enable(fen), .freq_choice_hi(fhi), .freq_choice_lo(flo),
		.pll_mode_sw_source(psrc), .pll_mode(pmode),
		.readback_count_field(cnt));
	cbr_host host (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl),
		.sda(sda));
	// 125 MHz core clock
	initial
	begin
		forever #4 core_clk = ~core_clk;
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// block write of one byte at location n
	task wr(input logic [7:0] n, input logic [7:0] d);
		logic [7:0] q;
		logic a;
		host.start;
		host.xfer(WA, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		host.xfer(n, 1'b1, q, a);
		host.xfer(8'h01, 1'b1, q, a);
		host.xfer(d, 1'b1, q, a);
		host.stop;
	endtask
	// read part: count byte, then k bytes, the last one refused
	task rdx(input int k, input logic [7:0] ec, output logic [7:0] q);
		logic a;
		host.start;
		host.xfer(RA, 1'b1, q, a);
		host.xfer(8'hff, 1'b0, q, a);
		chk(q, ec);
		for (int i = 1; i <= k; i++)
			host.xfer(8'hff, i == k, q, a);
		host.stop;
	endtask
	task rd(input logic [7:0] n, input int k, input logic [7:0] ec,
		output logic [7:0] q);
		logic a;
		host.start;
		host.xfer(WA, 1'b1, q, a);
		host.xfer(n, 1'b1, q, a);
		rdx(k, ec, q);
	endtask
	task t_reset;
		logic [7:0] q;
		chk({4'h0, ed, ec, eb, ea}, 8'h0f);
		chk({7'h0, fb}, 8'h01);
		chk({5'h0, fen, fhi, flo}, 8'h00);
		chk({6'h0, pmode}, 8'h01);
		chk({3'h0, cnt}, 8'h08);
		chk({7'h0, sdo}, 8'h00);
		chk({4'h0, oen}, 8'h0f);
		chk({6'h0, amp}, 8'h02);
		rd(REG_PLL, 1, 8'h08, q);
		chk(q, 8'h46);
		rd(REG_SLEW, 1, 8'h08, q);
		chk(q, 8'hff);
		rd(REG_FREQ, 1, 8'h08, q);
		chk(q, 8'hc7);
		rd(REG_CNT, 1, 8'h08, q);
		chk(q, 8'h08);
		$display("reset test done");
	endtask
	task t_slew;
		logic [7:0] q;
		int p[4];
		p = '{1, 3, 5, 6};
		wr(REG_SLEW, 8'h00);
		chk({4'h0, ed, ec, eb, ea}, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(REG_SLEW, 8'h01 << p[i]);
			chk({4'h0, ed, ec, eb, ea}, 8'h01 << i);
			rd(REG_SLEW, 1, 8'h08, q);
			chk(q, 8'h95 | (8'h01 << p[i]));
		end
		wr(REG_SLEW, 8'hff);
		$display("slew test done");
	endtask
	task t_freq;
		logic [7:0] q;
		wr(REG_FREQ, 8'h18);
		chk({5'h0, fen, fhi, flo}, 8'h00);
		wr(REG_FREQ, 8'h38);
		chk({5'h0, fen, fhi, flo}, 8'h04);
		wr(REG_PLL, 8'h32);
		chk({5'h0, psrc, pmode}, 8'h06);
		chk({5'h0, fen, fhi, flo}, 8'h07);
		wr(REG_FREQ, 8'h00);
		chk({4'h0, fb, fen, fhi, flo}, 8'h00);
		rd(REG_FREQ, 1, 8'h08, q);
		chk(q, 8'hc6);
		wr(REG_FREQ, 8'h01);
		chk({7'h0, fb}, 8'h01);
		wr(REG_PLL, 8'h12);
		chk({5'h0, psrc, pmode}, 8'h01);
		$display("frequency test done");
	endtask
	task t_ro;
		logic [7:0] q;
		logic [7:0] e[3];
		e = '{8'hff, {REVISION_ID, VENDOR_ID},
			{TYPE_ZERO_DELAY_BUFFER, PART_IDENT}};
		for (int i = 0; i < 3; i++)
		begin
			wr(REG_RSVD4 + 8'(i), ~e[i]);
			rd(REG_RSVD4 + 8'(i), 1, 8'h08, q);
			chk(q, e[i]);
		end
		wr(8'h09, 8'h5a);
		rd(8'h09, 1, 8'h08, q);
		chk(q, UNMAPPED_VAL);
		$display("read-only test done");
	endtask
	task t_count;
		logic [7:0] q;
		wr(REG_CNT, 8'hff);
		chk({3'h0, cnt}, 8'h1f);
		rd(REG_CNT, 1, 8'h1f, q);
		chk(q, 8'h1f);
		wr(REG_CNT, 8'h02);
		rd(REG_REVV, 3, 8'h02, q);
		chk(q, 8'hff);
		wr(REG_CNT, 8'h08);
		$display("count test done");
	endtask
	task t_bus;
		logic [7:0] q;
		logic a;
		host.start;
		host.xfer(8'hd0, 1'b1, q, a);
		chk({7'h0, a}, 8'h01);
		host.stop;
		host.start;
		host.xfer(WA, 1'b1, q, a);
		host.xfer(REG_REVV, 1'b1, q, a);
		host.stop;
		rdx(1, 8'h08, q);
		chk(q, {REVISION_ID, VENDOR_ID});
		// a byte past the announced count is refused and lands nowhere
		host.start;
		host.xfer(WA, 1'b1, q, a);
		host.xfer(REG_SLEW, 1'b1, q, a);
		host.xfer(8'h01, 1'b1, q, a);
		host.xfer(8'hff, 1'b1, q, a);
		host.xfer(8'h00, 1'b1, q, a);
		chk({7'h0, a}, 8'h01);
		host.stop;
		chk({7'h0, fb}, 8'h01);
		$display("bus test done");
	endtask
	// reset for four cycles, let the sync settle, then run the tests
	initial
	begin
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		repeat (8) @(negedge core_clk);
		t_reset;
		t_slew;
		t_freq;
		t_ro;
		t_count;
		t_bus;
		tally_and_finish;
	end
	// tests need about 38k cycles; this cuts a hang short at 100k
	initial
	begin
		#800000;
		n_fail++;
		tally_and_finish;
	end
endmodule
